// file: hdl/oscsw_cfg.svh
// register map, field positions, reset values and keys of the oscillator control block
`ifndef OSCSW_CFG_SVH
`define OSCSW_CFG_SVH
`define OSW_ADDR_W       8
`define OSW_OFF_CTRL     8'h00
`define OSW_OFF_TUNE     8'h04
`define OSW_OFF_UNLOCK   8'h08
`define OSW_CUR_HI       14
`define OSW_CUR_LO       12
`define OSW_REQ_HI       10
`define OSW_REQ_LO       8
`define OSW_BIT_FREEZE   7
`define OSW_BIT_PINLOCK  6
`define OSW_BIT_PLLLOCK  5
`define OSW_BIT_FAIL     3
`define OSW_BIT_PKEEP    2
`define OSW_BIT_SECEN    1
`define OSW_BIT_SWREQ    0
`define OSW_TRIM_W       6
`define OSW_TRIM_RST     6'h00
`define OSW_KEY1         8'h46
`define OSW_KEY2         8'h57
`define OSW_SWITCH_CYC   4
`define OSW_RESP_OKAY    2'h0
`define OSW_RESP_SLVERR  2'h2
`define OSW_SWM_ON       2'h0
`endif

// file: hdl/oscsw_ctrl.sv
// oscillator source select, switch, lock and trim control with AXI4-Lite registers
`include "oscsw_cfg.svh"
`default_nettype none
module oscsw_ctrl #(
  parameter int unsigned SWITCH_CYCLES = `OSW_SWITCH_CYC
) (
  input  wire logic                   clock_in,
  input  wire logic                   reset_in,
  input  wire logic [`OSW_ADDR_W-1:0] s_axi_awaddr_in,
  input  wire logic                   s_axi_awvalid_in,
  output logic                        s_axi_awready_out,
  input  wire logic [31:0]            s_axi_wdata_in,
  input  wire logic [3:0]             s_axi_wstrb_in,
  input  wire logic                   s_axi_wvalid_in,
  output logic                        s_axi_wready_out,
  output logic [1:0]                  s_axi_bresp_out,
  output logic                        s_axi_bvalid_out,
  input  wire logic                   s_axi_bready_in,
  input  wire logic [`OSW_ADDR_W-1:0] s_axi_araddr_in,
  input  wire logic                   s_axi_arvalid_in,
  output logic                        s_axi_arready_out,
  output logic [31:0]                 s_axi_rdata_out,
  output logic [1:0]                  s_axi_rresp_out,
  output logic                        s_axi_rvalid_out,
  input  wire logic                   s_axi_rready_in,
  input  wire logic [2:0]             initial_source_fuses_in,
  input  wire logic                   one_way_pin_freeze_fuse_in,
  input  wire logic [1:0]             switch_monitor_fuses_in,
  input  wire logic [1:0]             primary_submode_fuses_in,
  input  wire logic                   pll_locked_in,
  input  wire logic                   clock_fail_event_in,
  output oscsw_pkg::oscsw_src_t       current_source_out,
  output logic [`OSW_TRIM_W-1:0]      fast_osc_trim_out,
  output logic [1:0]                  primary_submode_out,
  output logic                        pin_config_freeze_out,
  output logic                        switch_enable_out,
  output logic                        monitor_enable_out,
  output logic                        primary_keep_in_sleep_out,
  output logic                        secondary_enable_out
);
  import oscsw_pkg::*;

  // fuses and status pins come from outside this clock: two flops first
  logic [9:0] sync1_r;
  logic [9:0] sync2_r;
  always_ff @(posedge clock_in) begin
    sync1_r <= {initial_source_fuses_in, one_way_pin_freeze_fuse_in,
                switch_monitor_fuses_in, primary_submode_fuses_in,
                pll_locked_in, clock_fail_event_in};
    sync2_r <= sync1_r;
  end
  logic [2:0] init_src_s;
  logic       one_way_s;
  logic [1:0] swm_s;
  logic [1:0] submode_s;
  logic       pll_lock_s;
  logic       fail_evt_s;
  assign {init_src_s, one_way_s, swm_s, submode_s, pll_lock_s, fail_evt_s} = sync2_r;

  // configuration decoded into flops
  logic switch_en_r;
  logic monitor_en_r;
  logic one_way_r;
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      switch_en_r  <= 1'b0;
      monitor_en_r <= 1'b0;
      one_way_r    <= 1'b0;
    end else begin
      switch_en_r  <= (swm_s == `OSW_SWM_ON);
      monitor_en_r <= ~swm_s[1];
      one_way_r    <= one_way_s;
    end
  end

  // AXI4-Lite write path: address and data are taken together
  logic        awready_r;
  logic        wready_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        wr_go;
  logic        wr_fire;
  logic [7:0]  wr_off;
  assign wr_go   = s_axi_awvalid_in & s_axi_wvalid_in & ~awready_r & ~bvalid_r;
  assign wr_fire = s_axi_awvalid_in & awready_r & s_axi_wvalid_in & wready_r;
  assign wr_off  = {s_axi_awaddr_in[7:2], 2'h0};
  logic wr_ctrl;
  logic wr_tune;
  logic wr_unl;
  assign wr_ctrl = wr_fire & (wr_off == `OSW_OFF_CTRL);
  assign wr_tune = wr_fire & (wr_off == `OSW_OFF_TUNE);
  assign wr_unl  = wr_fire & (wr_off == `OSW_OFF_UNLOCK);
  logic b0;
  logic b1;
  assign b0 = s_axi_wstrb_in[0];
  assign b1 = s_axi_wstrb_in[1];

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= `OSW_RESP_OKAY;
    end else begin
      awready_r <= wr_go;
      wready_r  <= wr_go;
      if (wr_fire) begin
        bvalid_r <= 1'b1;
        bresp_r  <= (wr_ctrl | wr_tune | wr_unl) ? `OSW_RESP_OKAY : `OSW_RESP_SLVERR;
      end else if (s_axi_bready_in) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // unlock sequence: two keys in a row arm one following control write
  oscsw_unlock_t unl_r;
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      unl_r <= OSW_UNL_NONE;
    end else if (wr_unl & b0) begin
      if (unl_r == OSW_UNL_KEY1 && s_axi_wdata_in[7:0] == `OSW_KEY2) begin
        unl_r <= OSW_UNL_ARMED;
      end else if (s_axi_wdata_in[7:0] == `OSW_KEY1) begin
        unl_r <= OSW_UNL_KEY1;
      end else begin
        unl_r <= OSW_UNL_NONE;
      end
    end else if (wr_fire) begin
      unl_r <= OSW_UNL_NONE; // any other write consumes or breaks the sequence
    end
  end

  // source selection and switch sequencing
  oscsw_src_t    cur_r;
  oscsw_src_t    req_r;
  oscsw_src_t    target_r;
  oscsw_state_t  st_r;
  logic [7:0]    cnt_r;
  logic          swreq_r;
  logic          freeze_r;
  logic          ctrl_wr_ok;
  assign ctrl_wr_ok = wr_ctrl & ~freeze_r;

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      req_r <= oscsw_src_t'(init_src_s);
    end else if (ctrl_wr_ok & b1) begin
      req_r <= oscsw_src_t'(s_axi_wdata_in[`OSW_REQ_HI:`OSW_REQ_LO]);
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      cur_r    <= oscsw_src_t'(init_src_s);
      target_r <= OSW_SRC_FAST_RC;
      st_r     <= OSW_ST_IDLE;
      cnt_r    <= 8'h00;
      swreq_r  <= 1'b0;
    end else if (!switch_en_r) begin
      cur_r   <= oscsw_src_t'(init_src_s);
      st_r    <= OSW_ST_IDLE;
      swreq_r <= 1'b0;
    end else begin
      unique case (st_r)
        OSW_ST_IDLE: begin
          if (swreq_r) begin
            // reserved code is not a valid target: request simply drops
            if (req_r == OSW_SRC_RESERVED) begin
              swreq_r <= 1'b0;
            end else begin
              target_r <= req_r;
              cnt_r    <= 8'(SWITCH_CYCLES - 1);
              st_r     <= OSW_ST_SWITCH;
            end
          end else if (ctrl_wr_ok & b0 & s_axi_wdata_in[`OSW_BIT_SWREQ]) begin
            swreq_r <= 1'b1;
          end
        end
        OSW_ST_SWITCH: begin
          if (cnt_r == 8'h00) begin
            cur_r   <= target_r;
            swreq_r <= 1'b0;
            st_r    <= OSW_ST_IDLE;
          end else begin
            cnt_r <= cnt_r - 8'h01;
          end
        end
      endcase
    end
  end

  // lock, freeze and flag bits
  logic pll_mode;
  logic lock_r;
  logic fail_r;
  logic pinlock_r;
  logic pkeep_r;
  logic secen_r;
  assign pll_mode = (cur_r == OSW_SRC_FAST_RC_PLL) | (cur_r == OSW_SRC_PRIMARY_PLL);

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      lock_r <= 1'b0;
    end else begin
      lock_r <= pll_lock_s & pll_mode & (st_r == OSW_ST_IDLE);
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      fail_r <= 1'b0;
    end else if (fail_evt_s & monitor_en_r) begin
      fail_r <= 1'b1; // a failure beats a clear in the same cycle
    end else if (wr_ctrl & b0 & ~s_axi_wdata_in[`OSW_BIT_FAIL]) begin
      fail_r <= 1'b0;
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      freeze_r <= 1'b0;
    end else if (wr_ctrl & b0 & s_axi_wdata_in[`OSW_BIT_FREEZE]) begin
      freeze_r <= 1'b1;
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      pinlock_r <= 1'b0;
    end else if (wr_ctrl & b0 & (unl_r == OSW_UNL_ARMED)) begin
      pinlock_r <= s_axi_wdata_in[`OSW_BIT_PINLOCK] | (pinlock_r & one_way_r);
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      pkeep_r <= 1'b0;
      secen_r <= 1'b0;
    end else if (wr_ctrl & b0) begin
      pkeep_r <= s_axi_wdata_in[`OSW_BIT_PKEEP];
      secen_r <= s_axi_wdata_in[`OSW_BIT_SECEN];
    end
  end

  // trim is only stored; its frequency effect is not modelled here
  logic [`OSW_TRIM_W-1:0] trim_r;
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      trim_r <= `OSW_TRIM_RST;
    end else if (wr_tune & b0) begin
      trim_r <= s_axi_wdata_in[`OSW_TRIM_W-1:0];
    end
  end

  // AXI4-Lite read path
  logic        arready_r;
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;
  logic        ar_fire;
  logic [7:0]  rd_off;
  logic [15:0] ctrl_word;
  assign ar_fire = s_axi_arvalid_in & arready_r;
  assign rd_off  = {s_axi_araddr_in[7:2], 2'h0};
  always_comb begin
    ctrl_word = 16'h0000;
    ctrl_word[`OSW_CUR_HI:`OSW_CUR_LO] = cur_r;
    ctrl_word[`OSW_REQ_HI:`OSW_REQ_LO] = req_r;
    ctrl_word[`OSW_BIT_FREEZE]  = freeze_r;
    ctrl_word[`OSW_BIT_PINLOCK] = pinlock_r;
    ctrl_word[`OSW_BIT_PLLLOCK] = lock_r;
    ctrl_word[`OSW_BIT_FAIL]    = fail_r;
    ctrl_word[`OSW_BIT_PKEEP]   = pkeep_r;
    ctrl_word[`OSW_BIT_SECEN]   = secen_r;
    ctrl_word[`OSW_BIT_SWREQ]   = swreq_r;
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= `OSW_RESP_OKAY;
    end else begin
      arready_r <= s_axi_arvalid_in & ~arready_r & ~rvalid_r;
      if (ar_fire) begin
        rvalid_r <= 1'b1;
        rresp_r  <= `OSW_RESP_OKAY;
        unique case (rd_off)
          `OSW_OFF_CTRL:   rdata_r <= {16'h0000, ctrl_word};
          `OSW_OFF_TUNE:   rdata_r <= {26'h0, trim_r};
          `OSW_OFF_UNLOCK: rdata_r <= 32'h0000_0000;
          default: begin
            rdata_r <= 32'h0000_0000;
            rresp_r <= `OSW_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rready_in) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  // outputs, all from flops
  logic [1:0] submode_r;
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      submode_r <= 2'h0;
    end else begin
      submode_r <= submode_s; // no register path can change it
    end
  end

  assign s_axi_awready_out         = awready_r;
  assign s_axi_wready_out          = wready_r;
  assign s_axi_bvalid_out          = bvalid_r;
  assign s_axi_bresp_out           = bresp_r;
  assign s_axi_arready_out         = arready_r;
  assign s_axi_rvalid_out          = rvalid_r;
  assign s_axi_rdata_out           = rdata_r;
  assign s_axi_rresp_out           = rresp_r;
  assign current_source_out        = cur_r;
  assign fast_osc_trim_out         = trim_r;
  assign primary_submode_out       = submode_r;
  assign pin_config_freeze_out     = pinlock_r;
  assign switch_enable_out         = switch_en_r;
  assign monitor_enable_out        = monitor_en_r;
  assign primary_keep_in_sleep_out = pkeep_r;
  assign secondary_enable_out      = secen_r;

  // checks
  cur_from_fuse_a: assert property (@(posedge clock_in) disable iff (reset_in)
    !switch_en_r |=> cur_r == $past(init_src_s))
    else $error("current source not from fuses while switching off");
  req_held_low_a: assert property (@(posedge clock_in) disable iff (reset_in)
    !switch_en_r ##1 !switch_en_r |-> !swreq_r)
    else $error("switch request set while switching off");
  lock_nonpll_a: assert property (@(posedge clock_in) disable iff (reset_in)
    (!pll_mode || st_r == OSW_ST_SWITCH) |=> !lock_r)
    else $error("pll lock shown in non-pll mode or during switch");
  freeze_sticky_a: assert property (@(posedge clock_in) disable iff (reset_in)
    freeze_r |=> freeze_r)
    else $error("source change freeze was cleared");
  fail_set_cause_a: assert property (@(posedge clock_in) disable iff (reset_in)
    !fail_r ##1 fail_r |-> $past(fail_evt_s) && $past(monitor_en_r))
    else $error("clock fail flag set without a failure");
  pin_one_way_a: assert property (@(posedge clock_in) disable iff (reset_in)
    pinlock_r && one_way_r |=> pinlock_r)
    else $error("pin freeze cleared under one-way fuse");
  pin_unlock_a: assert property (@(posedge clock_in) disable iff (reset_in)
    $changed(pinlock_r) |-> $past(unl_r) == OSW_UNL_ARMED && $past(wr_ctrl))
    else $error("pin freeze changed without unlock");
  switch_done_a: assert property (@(posedge clock_in) disable iff (reset_in)
    st_r == OSW_ST_SWITCH && cnt_r == 8'h00 && switch_en_r
      |=> cur_r == $past(target_r) && !swreq_r && st_r == OSW_ST_IDLE)
    else $error("switch did not complete correctly");
  trim_store_a: assert property (@(posedge clock_in) disable iff (reset_in)
    wr_tune && b0 |=> fast_osc_trim_out == $past(s_axi_wdata_in[`OSW_TRIM_W-1:0]))
    else $error("trim value not stored");
  write_resp_a: assert property (@(posedge clock_in) disable iff (reset_in)
    wr_fire |=> bvalid_r)
    else $error("write response missing");
  resp_hold_a: assert property (@(posedge clock_in) disable iff (reset_in)
    bvalid_r && !s_axi_bready_in |=> bvalid_r && $stable(bresp_r))
    else $error("write response dropped before it was taken");
endmodule
`default_nettype wire

// file: hdl/oscsw_pkg.sv
// types shared by the oscillator control block
`default_nettype none
package oscsw_pkg;
  typedef enum logic [2:0] {
    OSW_SRC_FAST_RC      = 3'h0,
    OSW_SRC_FAST_RC_PLL  = 3'h1,
    OSW_SRC_PRIMARY      = 3'h2,
    OSW_SRC_PRIMARY_PLL  = 3'h3,
    OSW_SRC_SECONDARY    = 3'h4,
    OSW_SRC_LOW_POWER_RC = 3'h5,
    OSW_SRC_RESERVED     = 3'h6,
    OSW_SRC_FAST_RC_DIV  = 3'h7
  } oscsw_src_t;
  typedef enum logic [0:0] {
    OSW_ST_IDLE   = 1'b0,
    OSW_ST_SWITCH = 1'b1
  } oscsw_state_t;
  typedef enum logic [1:0] {
    OSW_UNL_NONE  = 2'h0,
    OSW_UNL_KEY1  = 2'h1,
    OSW_UNL_ARMED = 2'h2
  } oscsw_unlock_t;
endpackage
`default_nettype wire

// file: verif/tb.sv
// self-checking bench for the oscillator control block over its register bus
`include "oscsw_cfg.svh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import oscsw_pkg::*;

  localparam logic [7:0] ctl = `OSW_OFF_CTRL;
  localparam logic [7:0] fast_osc_trim = `OSW_OFF_TUNE;
  localparam logic [7:0] unl = `OSW_OFF_UNLOCK;

  logic        clock_in = 1'b0;
  logic        reset_in = 1'b1;
  logic [7:0]  s_axi_awaddr_in = 8'h00;
  logic [7:0]  s_axi_araddr_in = 8'h00;
  logic [31:0] s_axi_wdata_in = 32'h0;
  logic [3:0]  s_axi_wstrb_in = 4'hF;
  logic        s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0, s_axi_bready_in = 1'b0;
  logic        s_axi_arvalid_in = 1'b0, s_axi_rready_in = 1'b0;
  logic [2:0]  initial_source_fuses_in = 3'h7;
  logic        one_way_pin_freeze_fuse_in = 1'b1, pll_locked_in = 1'b1;
  logic        clock_fail_event_in = 1'b0;
  logic [1:0]  switch_monitor_fuses_in = 2'h0, primary_submode_fuses_in = 2'h1;
  logic        s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
  logic        s_axi_rvalid_out, pin_config_freeze_out, switch_enable_out, monitor_enable_out;
  logic        primary_keep_in_sleep_out, secondary_enable_out;
  logic [1:0]  s_axi_bresp_out, s_axi_rresp_out, primary_submode_out;
  logic [31:0] s_axi_rdata_out;
  logic [5:0]  fast_osc_trim_out;
  oscsw_src_t  current_source_out;
  int          err_count = 0, compares = 0, cyc = 0;
  logic [31:0] rd;
  logic [1:0]  rsp;
  logic [5:0]  tv [3] = '{6'h1F, 6'h20, 6'h00};
  logic [2:0]  sw [7] = '{3'h3, 3'h4, 3'h2, 3'h5, 3'h1, 3'h6, 3'h0};

  always #50 clock_in = ~clock_in;

  oscsw_ctrl #(.SWITCH_CYCLES(4)) DUT (
    .clock_in, .reset_in, .s_axi_awaddr_in, .s_axi_awvalid_in, .s_axi_awready_out,
    .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in, .s_axi_wready_out,
    .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_araddr_in,
    .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out, .s_axi_rresp_out,
    .s_axi_rvalid_out, .s_axi_rready_in, .initial_source_fuses_in,
    .one_way_pin_freeze_fuse_in, .switch_monitor_fuses_in, .primary_submode_fuses_in,
    .pll_locked_in, .clock_fail_event_in, .current_source_out, .fast_osc_trim_out,
    .primary_submode_out, .pin_config_freeze_out, .switch_enable_out, .monitor_enable_out,
    .primary_keep_in_sleep_out, .secondary_enable_out);

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // address and data offered together; both readies arrive in the same cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_in);
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= d;
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in <= 1'b1;
    s_axi_bready_in <= 1'b1;
    do
      @(posedge clock_in);
    while (s_axi_awready_out !== 1'b1 || s_axi_wready_out !== 1'b1);
    s_axi_awvalid_in <= 1'b0;
    s_axi_wvalid_in <= 1'b0;
    do
      @(posedge clock_in);
    while (s_axi_bvalid_out !== 1'b1);
    rsp = s_axi_bresp_out;
    s_axi_bready_in <= 1'b0;
  endtask

  task automatic rdx(input logic [7:0] a);
    @(posedge clock_in);
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'b1;
    s_axi_rready_in <= 1'b1;
    do
      @(posedge clock_in);
    while (s_axi_arready_out !== 1'b1);
    s_axi_arvalid_in <= 1'b0;
    do
      @(posedge clock_in);
    while (s_axi_rvalid_out !== 1'b1);
    rd = s_axi_rdata_out;
    rsp = s_axi_rresp_out;
    s_axi_rready_in <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    rdx(a);
    chk(rd, e);
  endtask

  task automatic unlock();
    wr(unl, 32'h46);
    wr(unl, 32'h57);
  endtask

  // the request bit drops by itself once the new source runs, or a cycle after it is set for the reserved code
  task automatic poll();
    int n;
    n = 0;
    do begin
      rdx(ctl);
      n++;
    end while (rd[0] !== 1'b0 && n < 30);
  endtask

  // fuse sync flops are not reset, so fuses settle well inside the reset time
  task automatic rst(input logic [1:0] sm, input logic [2:0] ini);
    @(posedge clock_in);
    reset_in <= 1'b1;
    switch_monitor_fuses_in <= sm;
    initial_source_fuses_in <= ini;
    repeat (12) @(posedge clock_in);
    reset_in <= 1'b0;
  endtask

  task automatic tally_and_finish();
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  always @(posedge clock_in) begin
    cyc++;
    if (cyc == 8000) begin
      err_count++;
      tally_and_finish();
    end
  end

  initial begin
    logic [2:0] cur;
    logic       lk;
    rst(2'h0, 3'h7);
    rdchk(ctl, 32'h7700);
    chk({30'h0, switch_enable_out, monitor_enable_out}, 32'h3);
    for (int i = 0; i < 3; i++) begin
      wr(fast_osc_trim, {26'h3FFFFFF, tv[i]});
      rdchk(fast_osc_trim, {26'h0, tv[i]});
      chk({26'h0, fast_osc_trim_out}, {26'h0, tv[i]});
    end
    wr(ctl, 32'h0740);
    chk({30'h0, rsp}, 32'h0);
    rdchk(ctl, 32'h7700);
    unlock();
    wr(ctl, 32'h0740);
    rdchk(ctl, 32'h7740);
    unlock();
    wr(ctl, 32'h0700);
    rdchk(ctl, 32'h7740);
    chk({31'h0, pin_config_freeze_out}, 32'h1);
    cur = 3'h7;
    for (int i = 0; i < 7; i++) begin
      wr(ctl, {21'h0, sw[i], 8'h41});
      poll();
      if (sw[i] != 3'h6)
        cur = sw[i];
      lk = (cur == 3'h3 || cur == 3'h1);
      chk(rd, {17'h0, cur, 1'b0, sw[i], 2'b01, lk, 5'h00});
      chk({29'h0, current_source_out}, {29'h0, cur});
      if (lk) begin
        // losing lock in a pll mode must clear the status bit
        pll_locked_in <= 1'b0;
        repeat (4) @(posedge clock_in);
        rdchk(ctl, {17'h0, cur, 1'b0, sw[i], 8'h40});
        pll_locked_in <= 1'b1;
        repeat (4) @(posedge clock_in);
      end
    end
    chk({30'h0, primary_submode_out}, 32'h1);
    clock_fail_event_in <= 1'b1;
    repeat (4) @(posedge clock_in);
    clock_fail_event_in <= 1'b0;
    rdchk(ctl, 32'h0048);
    wr(ctl, 32'h0048);
    rdchk(ctl, 32'h0048);
    wr(ctl, 32'h0040);
    rdchk(ctl, 32'h0040);
    wr(ctl, 32'h00C0);
    rdchk(ctl, 32'h00C0);
    wr(ctl, 32'h0541);
    rdchk(ctl, 32'h00C0);
    wr(8'h0C, 32'h1);
    chk({30'h0, rsp}, 32'h2);
    rdx(8'h0C);
    chk({30'h0, rsp}, 32'h2);
    one_way_pin_freeze_fuse_in <= 1'b0;
    rst(2'h2, 3'h5);
    rdchk(ctl, 32'h5500);
    chk({30'h0, switch_enable_out, monitor_enable_out}, 32'h0);
    wr(ctl, 32'h0201);
    rdchk(ctl, 32'h5200);
    initial_source_fuses_in <= 3'h4;
    clock_fail_event_in <= 1'b1;
    repeat (6) @(posedge clock_in);
    clock_fail_event_in <= 1'b0;
    rdchk(ctl, 32'h4200);
    chk({29'h0, current_source_out}, 32'h4);
    unlock();
    wr(ctl, 32'h0240);
    rdchk(ctl, 32'h4240);
    unlock();
    wr(ctl, 32'h0200);
    rdchk(ctl, 32'h4200);
    rst(2'h1, 3'h0);
    repeat (3) @(posedge clock_in);
    chk({30'h0, switch_enable_out, monitor_enable_out}, 32'h1);
    wr(ctl, 32'h0201);
    rdchk(ctl, 32'h0200);
    wr(ctl, 32'h0206);
    rdchk(ctl, 32'h0206);
    chk({30'h0, primary_keep_in_sleep_out, secondary_enable_out}, 32'h3);
    tally_and_finish();
  end
endmodule
`default_nettype wire
